/* rtl/brk_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "brk_map.vh"

// Functional notes
// - two channels, independent or sequential break
// - sequential: a then b, later cycle
// - 32-bit address compare, per-bit maskable
// - address from l bus or i bus
// - channel b only: masked 32-bit data compare
// - satisfied condition raises break request
// - fetch break before or after execution
// - channel b 12-bit repeat count
// - keep last four branch source/destination pairs
// - channel a address register, resets zero
// - mask bit 1 ignores address bit
// - cycle select bits 15:8 read zero
// - bus select: off, l, i, l
// - kind: off, fetch, data, either
// - direction: off, read, write, both
// - size: any, byte, word, longword
module brk_top (
  input  wire        SYS_CLK,
  input  wire        RESET_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        BUS_VALID,
  input  wire        BUS_IS_IBUS,
  input  wire [31:0] LBUS_ADDRESS,
  input  wire [31:0] IBUS_ADDRESS,
  input  wire [31:0] LOGIC_DATA_BUS,
  input  wire [31:0] INTERNAL_DATA_BUS,
  input  wire        BUS_FETCH,
  input  wire        BUS_WRITE,
  input  wire [1:0]  BUS_SIZE,
  input  wire        INSN_DONE,
  input  wire        BRANCH_VALID,
  input  wire [31:0] BRANCH_SRC,
  input  wire [31:0] BRANCH_DST,
  output reg         BREAK_REQ,
  output reg         IRQ
);

  // ----------------------------------------
  // software visible and internal state
  // ----------------------------------------
  reg  [31:0] break_addr_a;        // channel a address
  reg  [31:0] break_addr_mask_a;   // channel a address mask
  reg  [7:0]  break_cycle_select_a;// channel a cycle fields, upper byte not stored
  reg  [31:0] break_addr_b;        // channel b address
  reg  [31:0] break_addr_mask_b;   // channel b address mask
  reg  [7:0]  break_cycle_select_b;// channel b cycle fields
  reg  [31:0] break_data_b;        // channel b data
  reg  [31:0] break_data_mask_b;   // channel b data mask
  reg  [3:0]  break_ctrl;          // sequence, after-exec, data bus select
  reg  [11:0] repeat_count;        // channel b repeat target
  reg  [11:0] repeat_hits;         // channel b matches so far
  reg  [1:0]  status;              // sticky break events
  reg  [1:0]  irq_mask;            // 1 = event drives irq
  reg  [31:0] trace_src [0:3];     // branch sources, entry 0 newest
  reg  [31:0] trace_dst [0:3];     // branch destinations
  reg         armed_a;             // channel a seen, waiting for b
  reg         pend_a;              // after-exec break held for channel a
  reg         pend_b;              // after-exec break held for channel b

  // ----------------------------------------
  // channel comparators
  // ----------------------------------------
  wire match_a;        // channel a hit pulse
  wire fetch_a;        // that hit was a fetch
  wire match_b;        // channel b hit pulse
  wire fetch_b;        // that hit was a fetch

  // both channels watch one cpu bus
  // and pick their own address source
  // channel a has no data compare: full mask makes data always agree
  brk_chan u_chan_a (
    .clk               (SYS_CLK),
    .rst_n             (RESET_N),
    .cycle_select      (break_cycle_select_a),
    .break_addr        (break_addr_a),
    .addr_mask         (break_addr_mask_a),
    .break_data        (`BRK_RST_WORD),
    .data_mask         (~`BRK_RST_WORD),
    .data_bus_sel      (1'b0),
    .bus_valid         (BUS_VALID),
    .bus_is_ibus       (BUS_IS_IBUS),
    .lbus_address      (LBUS_ADDRESS),
    .ibus_address      (IBUS_ADDRESS),
    .logic_data_bus    (LOGIC_DATA_BUS),
    .internal_data_bus (INTERNAL_DATA_BUS),
    .bus_fetch         (BUS_FETCH),
    .bus_write         (BUS_WRITE),
    .bus_size          (BUS_SIZE),
    .match             (match_a),
    .match_fetch       (fetch_a)
  );

  // channel b compares data too, bus picked by control
  brk_chan u_chan_b (
    .clk               (SYS_CLK),
    .rst_n             (RESET_N),
    .cycle_select      (break_cycle_select_b),
    .break_addr        (break_addr_b),
    .addr_mask         (break_addr_mask_b),
    .break_data        (break_data_b),
    .data_mask         (break_data_mask_b),
    .data_bus_sel      (break_ctrl[`BRK_CTL_DBUS_B]),
    .bus_valid         (BUS_VALID),
    .bus_is_ibus       (BUS_IS_IBUS),
    .lbus_address      (LBUS_ADDRESS),
    .ibus_address      (IBUS_ADDRESS),
    .logic_data_bus    (LOGIC_DATA_BUS),
    .internal_data_bus (INTERNAL_DATA_BUS),
    .bus_fetch         (BUS_FETCH),
    .bus_write         (BUS_WRITE),
    .bus_size          (BUS_SIZE),
    .match             (match_b),
    .match_fetch       (fetch_b)
  );

  // ----------------------------------------
  // break condition combining
  // ----------------------------------------
  wire seq_mode = break_ctrl[`BRK_CTL_SEQ];

  // both requests share one output;
  // status bits tell them apart
  // in sequence mode a only arms; b must come in a later cycle
  wire cond_b   = seq_mode ? (match_b && armed_a) : match_b;
  wire fire_a   = !seq_mode && match_a;

  // a lowered target still needs that
  // many channel b hits after the write
  wire [11:0] hits_inc = repeat_hits + 12'h001;
  // zero or one in the target means break on the first hit
  wire rep_done = (hits_inc >= repeat_count);
  wire fire_b   = cond_b && rep_done;

  // only a fetch has an instruction
  // that can retire, so data never waits
  // fetch breaks set for after-exec wait for the instruction to retire
  wire hold_a   = fire_a && fetch_a && break_ctrl[`BRK_CTL_AFTER_A];
  wire hold_b   = fire_b && fetch_b && break_ctrl[`BRK_CTL_AFTER_B];
  wire rel_a    = pend_a && INSN_DONE;
  wire rel_b    = pend_b && INSN_DONE;
  wire ev_a     = (fire_a && !hold_a) || rel_a;
  wire ev_b     = (fire_b && !hold_b) || rel_b;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire        apb_access = PSEL && PENABLE;
  wire        apb_done   = apb_access && PREADY;
  wire        wr_done    = apb_done && PWRITE;
  wire [1:0]  trace_idx  = PADDR[`BRK_TRACE_IDX_HI:`BRK_TRACE_IDX_LO];
  reg  [31:0] rd_mux;          // read data for the current address
  reg         rd_hit;          // address is mapped

  // read mux; unmapped addresses read zero and flag an error
  // reserved upper bits read zero
  always @* begin
    rd_mux = `BRK_RST_WORD;
    rd_hit = 1'b1;
    case (PADDR)
      `BRK_OFS_ADDR_A:   rd_mux = break_addr_a;
      `BRK_OFS_MASK_A:   rd_mux = break_addr_mask_a;
      `BRK_OFS_CYC_A:    rd_mux[`BRK_CYC_HI:0] = break_cycle_select_a;
      `BRK_OFS_ADDR_B:   rd_mux = break_addr_b;
      `BRK_OFS_MASK_B:   rd_mux = break_addr_mask_b;
      `BRK_OFS_CYC_B:    rd_mux[`BRK_CYC_HI:0] = break_cycle_select_b;
      `BRK_OFS_DATA_B:   rd_mux = break_data_b;
      `BRK_OFS_DMASK_B:  rd_mux = break_data_mask_b;
      `BRK_OFS_CTRL:     rd_mux[`BRK_CTL_HI:0] = break_ctrl;
      `BRK_OFS_REPEAT: begin
        rd_mux[`BRK_REP_HI:0]             = repeat_count;
        rd_mux[`BRK_HITS_HI:`BRK_HITS_LO] = repeat_hits;
      end
      `BRK_OFS_STATUS:   rd_mux[`BRK_ST_B:0] = status;
      `BRK_OFS_IRQ_MASK: rd_mux[`BRK_ST_B:0] = irq_mask;
      default: begin
        if ((PADDR & `BRK_TRACE_BASE_MSK) == `BRK_OFS_TRACE_SRC)
          rd_mux = trace_src[trace_idx];
        else if ((PADDR & `BRK_TRACE_BASE_MSK) == `BRK_OFS_TRACE_DST)
          rd_mux = trace_dst[trace_idx];
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // apb response: ready one cycle into access
  // ----------------------------------------
  // prdata is captured one edge before completion and held stable
  // the wait state puts a register
  // behind the wide read mux
  // writes return zero data
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= `BRK_RST_WORD;
    end else if (apb_access && !PREADY) begin
      PREADY  <= 1'b1;
      PSLVERR <= !rd_hit;
      PRDATA  <= PWRITE ? `BRK_RST_WORD : rd_mux;
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= `BRK_RST_WORD;
    end
  end

  // ----------------------------------------
  // configuration writes
  // ----------------------------------------
  // status and trace ignore writes,
  // with no error response
  // unused upper bits are dropped
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      break_addr_a         <= `BRK_RST_WORD;
      break_addr_mask_a    <= `BRK_RST_WORD;
      break_cycle_select_a <= `BRK_RST_CYC;
      break_addr_b         <= `BRK_RST_WORD;
      break_addr_mask_b    <= `BRK_RST_WORD;
      break_cycle_select_b <= `BRK_RST_CYC;
      break_data_b         <= `BRK_RST_WORD;
      break_data_mask_b    <= `BRK_RST_WORD;
      break_ctrl           <= `BRK_RST_CTRL;
      repeat_count         <= `BRK_RST_REP;
      irq_mask             <= `BRK_RST_BITS2;
    end else if (wr_done) begin
      case (PADDR)
        `BRK_OFS_ADDR_A:   break_addr_a      <= PWDATA;
        `BRK_OFS_MASK_A:   break_addr_mask_a <= PWDATA;
        // upper byte has no storage, so it always reads zero
        `BRK_OFS_CYC_A:    break_cycle_select_a <= PWDATA[`BRK_CYC_HI:0];
        `BRK_OFS_ADDR_B:   break_addr_b      <= PWDATA;
        `BRK_OFS_MASK_B:   break_addr_mask_b <= PWDATA;
        `BRK_OFS_CYC_B:    break_cycle_select_b <= PWDATA[`BRK_CYC_HI:0];
        `BRK_OFS_DATA_B:   break_data_b      <= PWDATA;
        `BRK_OFS_DMASK_B:  break_data_mask_b <= PWDATA;
        `BRK_OFS_CTRL:     break_ctrl        <= PWDATA[`BRK_CTL_HI:0];
        `BRK_OFS_REPEAT:   repeat_count      <= PWDATA[`BRK_REP_HI:0];
        `BRK_OFS_IRQ_MASK: irq_mask          <= PWDATA[`BRK_ST_B:0];
        default: begin
          // read-only and unmapped words ignore writes
        end
      endcase
    end
  end

  // ----------------------------------------
  // sequence arm, repeat counter, after-exec holds
  // ----------------------------------------
  // a write to the repeat word restarts the count
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      armed_a     <= 1'b0;
      repeat_hits <= `BRK_RST_REP;
      pend_a      <= 1'b0;
      pend_b      <= 1'b0;
    end else begin
      // arm on a, drop once b completes the pair
      if (!seq_mode)
        armed_a <= 1'b0;
      else if (match_a)
        armed_a <= 1'b1;
      else if (cond_b)
        armed_a <= 1'b0;
      // a software restart beats a hit
      if (wr_done && PADDR == `BRK_OFS_REPEAT)
        repeat_hits <= `BRK_RST_REP;
      else if (fire_b)
        repeat_hits <= `BRK_RST_REP;
      else if (cond_b)
        repeat_hits <= hits_inc;
      // a fresh hold wins over a release in the same cycle
      pend_a <= hold_a || (pend_a && !INSN_DONE);
      pend_b <= hold_b || (pend_b && !INSN_DONE);
    end
  end

  // ----------------------------------------
  // break request, status and interrupt
  // ----------------------------------------
  // read clears only bits seen in prdata, new events always win
  // irq uses the next status, so it
  // rises with the break request
  wire       st_read  = apb_done && !PWRITE && PADDR == `BRK_OFS_STATUS;
  wire [1:0] ev_bits  = {ev_b, ev_a};
  wire [1:0] clr_bits = st_read ? PRDATA[`BRK_ST_B:0] : `BRK_RST_BITS2;
  wire [1:0] next_status = (status & ~clr_bits) | ev_bits;

  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BREAK_REQ <= 1'b0;
      status    <= `BRK_RST_BITS2;
      IRQ       <= 1'b0;
    end else begin
      BREAK_REQ <= ev_a || ev_b;
      status    <= next_status;
      IRQ       <= |(next_status & irq_mask);
    end
  end

  // ----------------------------------------
  // branch trace, newest in entry 0
  // ----------------------------------------
  // only reset empties the trace
  // software has no clear for it
  integer i;
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (i = 0; i < `BRK_TRACE_DEPTH; i = i + 1) begin
        trace_src[i] <= `BRK_RST_WORD;
        trace_dst[i] <= `BRK_RST_WORD;
      end
    end else if (BRANCH_VALID) begin
      // oldest pair falls off the end
      for (i = `BRK_TRACE_DEPTH - 1; i > 0; i = i - 1) begin
        trace_src[i] <= trace_src[i-1];
        trace_dst[i] <= trace_dst[i-1];
      end
      trace_src[0] <= BRANCH_SRC;
      trace_dst[0] <= BRANCH_DST;
    end
  end

endmodule
`default_nettype wire

/* rtl/brk_map.vh */
`ifndef BRK_MAP_VH
`define BRK_MAP_VH

// ----------------------------------------
// register offsets on the apb side
// ----------------------------------------
`define BRK_OFS_ADDR_A      8'h00
`define BRK_OFS_MASK_A      8'h04
`define BRK_OFS_CYC_A       8'h08
`define BRK_OFS_ADDR_B      8'h0C
`define BRK_OFS_MASK_B      8'h10
`define BRK_OFS_CYC_B       8'h14
`define BRK_OFS_DATA_B      8'h18
`define BRK_OFS_DMASK_B     8'h1C
`define BRK_OFS_CTRL        8'h20
`define BRK_OFS_REPEAT      8'h24
`define BRK_OFS_STATUS      8'h28
`define BRK_OFS_IRQ_MASK    8'h2C
`define BRK_OFS_TRACE_SRC   8'h30
`define BRK_OFS_TRACE_DST   8'h40
`define BRK_TRACE_IDX_HI    3
`define BRK_TRACE_IDX_LO    2
`define BRK_TRACE_BASE_MSK  8'hF0

// ----------------------------------------
// reset values
// ----------------------------------------
`define BRK_RST_WORD        32'h00000000
`define BRK_RST_CYC         8'h00
`define BRK_RST_REP         12'h000
`define BRK_RST_BITS2       2'h0
`define BRK_RST_CTRL        4'h0

// ----------------------------------------
// cycle select field layout
// ----------------------------------------
`define BRK_CYC_HI          7
`define BRK_BUS_HI          7
`define BRK_BUS_LO          6
`define BRK_KIND_HI         5
`define BRK_KIND_LO         4
`define BRK_DIR_HI          3
`define BRK_DIR_LO          2
`define BRK_SIZE_HI         1
`define BRK_SIZE_LO         0

// ----------------------------------------
// field codes
// ----------------------------------------
`define BRK_CODE_OFF        2'h0
`define BRK_BUS_IBUS        2'h2
`define BRK_KIND_FETCH      2'h1
`define BRK_KIND_DATA       2'h2
`define BRK_DIR_READ        2'h1
`define BRK_DIR_WRITE       2'h2

// ----------------------------------------
// control, repeat, status bits
// ----------------------------------------
`define BRK_CTL_SEQ         0
`define BRK_CTL_AFTER_A     1
`define BRK_CTL_AFTER_B     2
`define BRK_CTL_DBUS_B      3
`define BRK_CTL_HI          3
`define BRK_REP_HI          11
`define BRK_HITS_LO         16
`define BRK_HITS_HI         27
`define BRK_ST_A            0
`define BRK_ST_B            1
`define BRK_TRACE_DEPTH     4

`endif

/* rtl/brk_chan.v */
`timescale 1ns/1ps
`default_nettype none
`include "brk_map.vh"

// one break channel: all enabled criteria must agree in one bus cycle
module brk_chan (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  cycle_select,   // bus / kind / direction / size fields
  input  wire [31:0] break_addr,     // compare address
  input  wire [31:0] addr_mask,      // 1 = bit ignored
  input  wire [31:0] break_data,     // compare data
  input  wire [31:0] data_mask,      // 1 = bit ignored
  input  wire        data_bus_sel,   // 0 logic data bus, 1 internal data bus
  input  wire        bus_valid,      // a bus cycle this clock
  input  wire        bus_is_ibus,    // 1 = i bus cycle, 0 = l bus cycle
  input  wire [31:0] lbus_address,
  input  wire [31:0] ibus_address,
  input  wire [31:0] logic_data_bus,
  input  wire [31:0] internal_data_bus,
  input  wire        bus_fetch,      // 1 = instruction fetch
  input  wire        bus_write,      // 1 = write
  input  wire [1:0]  bus_size,       // 01 byte, 10 word, 11 longword
  output reg         match,          // one-cycle pulse, a cycle after the bus cycle
  output reg         match_fetch     // the matched cycle was a fetch
);

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  wire [1:0]  sel_bus  = cycle_select[`BRK_BUS_HI:`BRK_BUS_LO];
  wire [1:0]  sel_kind = cycle_select[`BRK_KIND_HI:`BRK_KIND_LO];
  wire [1:0]  sel_dir  = cycle_select[`BRK_DIR_HI:`BRK_DIR_LO];
  wire [1:0]  sel_size = cycle_select[`BRK_SIZE_HI:`BRK_SIZE_LO];
  // all fields off keeps the channel silent
  wire        enabled  = |cycle_select;

  // address source: i bus for code 10, l bus for 01 and 11, the cycle's own bus for 00
  wire [31:0] cmp_addr = (sel_bus == `BRK_BUS_IBUS) ? ibus_address :
                         (sel_bus == `BRK_CODE_OFF) ?
                         (bus_is_ibus ? ibus_address : lbus_address) :
                         lbus_address;
  wire [31:0] cmp_data = data_bus_sel ? internal_data_bus : logic_data_bus;

  // ----------------------------------------
  // per-criterion checks, off = always true
  // ----------------------------------------
  wire addr_ok = ~|((cmp_addr ^ break_addr) & ~addr_mask);
  wire data_ok = ~|((cmp_data ^ break_data) & ~data_mask);
  wire bus_ok  = (sel_bus == `BRK_CODE_OFF) ||
                 ((sel_bus == `BRK_BUS_IBUS) ? bus_is_ibus : !bus_is_ibus);
  wire kind_ok = (sel_kind == `BRK_CODE_OFF) ||
                 (sel_kind[0] && bus_fetch) || (sel_kind[1] && !bus_fetch);
  wire dir_ok  = (sel_dir == `BRK_CODE_OFF) ||
                 (sel_dir[0] && !bus_write) || (sel_dir[1] && bus_write);
  wire size_ok = (sel_size == `BRK_CODE_OFF) || (sel_size == bus_size);

  wire hit = enabled && bus_valid && addr_ok && data_ok &&
             bus_ok && kind_ok && dir_ok && size_ok;

  // registered so the top sees clean single-cycle pulses
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match       <= 1'b0;
      match_fetch <= 1'b0;
    end else begin
      match       <= hit;
      match_fetch <= hit && bus_fetch;
    end
  end

endmodule
`default_nettype wire

/* verif/brk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker: apb timing and break/interrupt causes
// ----
module brk_asserts (
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        BUS_VALID,
  input wire logic        INSN_DONE,
  input wire logic        BREAK_REQ,
  input wire logic        IRQ
);
  // single domain, so one clock and one disable for all
  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  ready_pulse_a:
    assert property (PREADY |=> !PREADY) else $error("ready held over one cycle");
  wait_state_a:
    assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("access phase not exactly one wait state");
  err_ready_a:
    assert property (PSLVERR |-> PREADY) else $error("error without ready");
  rdata_idle_a:
    assert property (!PREADY || PWRITE |-> PRDATA == 32'h0) else $error("read data outside read");
  break_pulse_a:
    assert property (BREAK_REQ && !$past(BUS_VALID) && !INSN_DONE |=> !BREAK_REQ)
    else $error("break request longer than one cycle");
  break_cause_a:
    assert property (BREAK_REQ |-> $past(BUS_VALID, 2) || $past(INSN_DONE))
    else $error("break request without bus cycle or done");
  irq_rise_a:
    assert property ($rose(IRQ) |-> BREAK_REQ || $past(BUS_VALID, 2) || $past(INSN_DONE)
      || $past(PSEL && PWRITE) || $past(PSEL && PWRITE, 2)) else $error("interrupt without cause");
  irq_clear_a:
    assert property ($fell(IRQ) |-> $past(PREADY) || $past(PREADY, 2))
    else $error("interrupt dropped without register access");
endmodule
bind brk_top brk_asserts i_chk (.SYS_CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PRDATA,
  .PREADY, .PSLVERR, .BUS_VALID, .INSN_DONE, .BREAK_REQ, .IRQ);
`default_nettype wire

/* verif/brk_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// cpu side: one bus cycle per call, instruction-done and branch pulses
// ----
module brk_cpu_model (
  input  wire logic        clk,
  output logic             bus_valid,
  output logic             bus_is_ibus,
  output logic [31:0]      lbus_address,
  output logic [31:0]      ibus_address,
  output logic [31:0]      logic_data_bus,
  output logic [31:0]      internal_data_bus,
  output logic             bus_fetch,
  output logic             bus_write,
  output logic [1:0]       bus_size,
  output logic             insn_done,
  output logic             branch_valid,
  output logic [31:0]      branch_src,
  output logic [31:0]      branch_dst
);
  // idle lines start low, strobes low
  initial begin
    {bus_valid, bus_is_ibus, bus_fetch, bus_write, bus_size, insn_done, branch_valid} = '0;
    {lbus_address, ibus_address, logic_data_bus, internal_data_bus} = '0;
    {branch_src, branch_dst} = '0;
  end
  // the unused bus carries the inverse, so a wrong bus choice cannot match
  task automatic cycle(input logic ib, fe, wr, input logic [1:0] sz, input logic [31:0] a, d);
    @(posedge clk);
    {bus_valid, bus_is_ibus, bus_fetch, bus_write, bus_size} <= {1'h1, ib, fe, wr, sz};
    lbus_address <= ib ? ~a : a;
    ibus_address <= ib ? a : ~a;
    logic_data_bus <= d;
    internal_data_bus <= ~d;
    @(posedge clk);
    bus_valid <= 1'h0;
    // released lines flip so stale values never look valid
    {lbus_address, ibus_address, logic_data_bus, internal_data_bus, bus_fetch, bus_write,
      bus_size} <= ~{lbus_address, ibus_address, logic_data_bus, internal_data_bus,
      bus_fetch, bus_write, bus_size};
  endtask
  task automatic done();
    @(posedge clk);
    insn_done <= 1'h1;
    @(posedge clk);
    insn_done <= 1'h0;
  endtask
  task automatic branch(input logic [31:0] s, d);
    @(posedge clk);
    {branch_valid, branch_src, branch_dst} <= {1'h1, s, d};
    @(posedge clk);
    {branch_valid, branch_src, branch_dst} <= {1'h0, ~s, ~d};
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "brk_map.vh"
module testbench;
  localparam logic [31:0] ADDR_A = 32'h1234_5670;  // channel a target
  localparam logic [31:0] ADDR_B = 32'h0ABC_DEF0;  // channel b target
  localparam logic [31:0] DAT    = 32'h5A5A_00FF;  // channel b data
  logic        SYS_CLK = 1'h0;
  logic        RESET_N = 1'h0;
  logic        PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, rdat;
  logic        rerr;
  int          n_fail = 0, n_tests = 0, i;
  wire logic   PREADY, PSLVERR, BREAK_REQ, IRQ, BUS_VALID, BUS_IS_IBUS, BUS_FETCH, BUS_WRITE;
  wire logic   INSN_DONE, BRANCH_VALID;
  wire logic [1:0]  BUS_SIZE;
  wire logic [31:0] PRDATA, LBUS_ADDRESS, IBUS_ADDRESS, LOGIC_DATA_BUS, INTERNAL_DATA_BUS;
  wire logic [31:0] BRANCH_SRC, BRANCH_DST;
  // case: {cycle select, ibus, fetch, write, size, flip bit 4, mask bit 4, expect}
  logic [15:0] tbl [0:16] = '{16'h0018, 16'h4019, 16'h4098, 16'h8099, 16'hC019, 16'h1018,
    16'h2019, 16'h3059, 16'h0438, 16'h0839, 16'h0C19, 16'h0110, 16'h0211, 16'h0319,
    16'h6518, 16'h401F, 16'h401C};
  always #5 SYS_CLK = ~SYS_CLK;
  brk_top i_brk_top (.SYS_CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .BUS_VALID, .BUS_IS_IBUS, .LBUS_ADDRESS, .IBUS_ADDRESS,
    .LOGIC_DATA_BUS, .INTERNAL_DATA_BUS, .BUS_FETCH, .BUS_WRITE, .BUS_SIZE, .INSN_DONE,
    .BRANCH_VALID, .BRANCH_SRC, .BRANCH_DST, .BREAK_REQ, .IRQ);
  brk_cpu_model i_brk_cpu_model (.clk(SYS_CLK), .bus_valid(BUS_VALID), .bus_is_ibus(BUS_IS_IBUS),
    .lbus_address(LBUS_ADDRESS), .ibus_address(IBUS_ADDRESS), .logic_data_bus(LOGIC_DATA_BUS),
    .internal_data_bus(INTERNAL_DATA_BUS), .bus_fetch(BUS_FETCH), .bus_write(BUS_WRITE),
    .bus_size(BUS_SIZE), .insn_done(INSN_DONE), .branch_valid(BRANCH_VALID),
    .branch_src(BRANCH_SRC), .branch_dst(BRANCH_DST));
  // ----
  // closing report and compare
  // ----
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // apb transfer; an idle edge first so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge SYS_CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'h1, 1'h0, wr, a, wd};
    @(posedge SYS_CLK);
    PENABLE <= 1'h1;
    k = 0;
    do begin
      @(posedge SYS_CLK);
      k++;
    end while (PREADY !== 1'h1 && k < 16);
    // a slave that never answers ends the run
    if (PREADY !== 1'h1) begin
      n_fail++;
      stop_test();
    end
    rdat = PRDATA;
    rerr = PSLVERR;
    {PSEL, PENABLE} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask
  // request is due two cycles after the bus cycle
  task automatic brk(input logic exp);
    @(posedge SYS_CLK);
    #1;
    chk("break request", {31'h0, exp}, {31'h0, BREAK_REQ});
  endtask
  task automatic hit(input logic [31:0] a, d, input logic exp);
    i_brk_cpu_model.cycle(1'h0, 1'h0, 1'h0, 2'h3, a, d);
    brk(exp);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RESET_N <= 1'h1;
    rdc("addr a reset", `BRK_OFS_ADDR_A, 32'h0);
    rdc("mask a reset", `BRK_OFS_MASK_A, 32'h0);
    rdc("cycle a reset", `BRK_OFS_CYC_A, 32'h0);
    wr(`BRK_OFS_CYC_A, 32'hFFFF_FFFF);
    rdc("cycle a reserved", `BRK_OFS_CYC_A, 32'h0000_00FF);
    wr(`BRK_OFS_ADDR_A, ADDR_A);
    rdc("addr a", `BRK_OFS_ADDR_A, ADDR_A);
    apb(1'h0, 8'h50, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    wr(`BRK_OFS_IRQ_MASK, 32'h3);
    // every field code, bus choice and mask case on channel a
    for (i = 0; i < 17; i++) begin
      wr(`BRK_OFS_CYC_A, {24'h0, tbl[i][15:8]});
      wr(`BRK_OFS_MASK_A, tbl[i][1] ? 32'h10 : 32'h0);
      i_brk_cpu_model.cycle(tbl[i][7], tbl[i][6], tbl[i][5], tbl[i][4:3],
        ADDR_A ^ {27'h0, tbl[i][2], 4'h0}, 32'h0);
      brk(tbl[i][0]);
      chk("irq", {31'h0, tbl[i][0]}, {31'h0, IRQ});
      rdc("status a", `BRK_OFS_STATUS, {31'h0, tbl[i][0]});
    end
    wr(`BRK_OFS_IRQ_MASK, 32'h0);
    hit(ADDR_A, 32'h0, 1'h1);
    chk("masked irq", 32'h0, {31'h0, IRQ});
    rdc("status masked", `BRK_OFS_STATUS, 32'h1);
    // sequential: b before a and a alone must not break
    wr(`BRK_OFS_ADDR_B, ADDR_B);
    wr(`BRK_OFS_CYC_B, 32'h40);
    wr(`BRK_OFS_CTRL, 32'h1);
    hit(ADDR_B, 32'h0, 1'h0);
    hit(ADDR_A, 32'h0, 1'h0);
    hit(ADDR_B, 32'h0, 1'h1);
    rdc("status seq", `BRK_OFS_STATUS, 32'h2);
    wr(`BRK_OFS_CTRL, 32'h0);
    wr(`BRK_OFS_REPEAT, 32'h3);
    for (i = 1; i <= 3; i++) hit(ADDR_B, 32'h0, i == 3);
    rdc("repeat", `BRK_OFS_REPEAT, 32'h3);
    wr(`BRK_OFS_REPEAT, 32'h1);
    wr(`BRK_OFS_DATA_B, DAT);
    hit(ADDR_B, DAT, 1'h1);
    wr(`BRK_OFS_CTRL, 32'h8);
    hit(ADDR_B, DAT, 1'h0);
    hit(ADDR_B, ~DAT, 1'h1);
    // break after execution waits for the done pulse
    wr(`BRK_OFS_CTRL, 32'h2);
    wr(`BRK_OFS_CYC_A, 32'h50);
    i_brk_cpu_model.cycle(1'h0, 1'h1, 1'h0, 2'h3, ADDR_A, 32'h0);
    brk(1'h0);
    i_brk_cpu_model.done();
    #1;
    chk("break after", 32'h1, {31'h0, BREAK_REQ});
    wr(`BRK_OFS_CTRL, 32'h4);
    wr(`BRK_OFS_CYC_B, 32'h50);
    i_brk_cpu_model.cycle(1'h0, 1'h1, 1'h0, 2'h3, ADDR_B, DAT);
    brk(1'h0);
    i_brk_cpu_model.done();
    #1;
    chk("break after b", 32'h1, {31'h0, BREAK_REQ});
    for (i = 1; i <= 5; i++) i_brk_cpu_model.branch(32'(i), 32'(i + 256));
    rdc("trace src 0", `BRK_OFS_TRACE_SRC, 32'h5);
    rdc("trace src 3", `BRK_OFS_TRACE_SRC + 8'h0C, 32'h2);
    rdc("trace dst 0", `BRK_OFS_TRACE_DST, 32'h105);
    stop_test();
  end
endmodule
`default_nettype wire
